// ### src/rfcsm_pkg.sv
package rfcsm_pkg;
	// port count and register window
	localparam int unsigned PORT_COUNT = 8;
	localparam logic [11:0] PORT_STRIDE = 12'h200;
	localparam logic [8:0] OFF_SA8_HIST = 9'h06D;
	localparam logic [8:0] OFF_SA_LAST = 9'h06E;
	localparam logic [8:0] OFF_SA6_CODE = 9'h06F;
	localparam logic [8:0] OFF_MASTER_MODE = 9'h080;
	localparam logic [8:0] OFF_CONTROL_ONE = 9'h081;
	localparam logic [8:0] OFF_CONTROL_TWO = 9'h082;
	localparam logic [8:0] OFF_SA_MON_MASK = 9'h0F0;
	localparam logic [8:0] OFF_LATCHED_SEVEN = 9'h0F1;

	// master mode fields
	localparam int unsigned MM_FRAMER_EN = 7;
	localparam int unsigned MM_INIT_DONE = 6;
	localparam int unsigned MM_SYNC_DIS = 5;
	localparam int unsigned MM_SOFT_RST = 1;
	localparam int unsigned MM_STD_SEL = 0;

	// control one fields (t1 and e1 views share positions 6..0)
	localparam int unsigned C1_SYNC_QUAL = 7;
	localparam int unsigned C1_ZERO_SUP = 6;
	localparam int unsigned C1_FRAME_FMT = 5;
	localparam int unsigned C1_SIG_MODE = 5;
	localparam int unsigned C1_AUTO_CRIT = 4;
	localparam int unsigned C1_G802 = 4;
	localparam int unsigned C1_SYNC_CRIT = 3;
	localparam int unsigned C1_CRC_EN = 3;
	localparam int unsigned C1_JAP_CRC = 2;
	localparam int unsigned C1_RESYNC_CRIT = 2;
	localparam int unsigned C1_AUTO_DIS = 1;
	localparam int unsigned C1_RESYNC = 0;

	// control two fields
	localparam int unsigned C2_UP_LSB = 3;
	localparam int unsigned C2_DOWN_LSB = 0;
	localparam int unsigned C2_LOS_ALT = 0;

	// writable bit masks, reset values
	localparam logic [7:0] MASK_MASTER_MODE = 8'hE3;
	localparam logic [7:0] MASK_C1_T1 = 8'hFF;
	localparam logic [7:0] MASK_C1_E1 = 8'h7F;
	localparam logic [7:0] MASK_C2_T1 = 8'h3F;
	localparam logic [7:0] MASK_C2_E1 = 8'h01;
	localparam logic [7:0] MASK_SA_MON = 8'h1F;
	localparam logic [7:0] RESET_BYTE = 8'h00;

	// framer thresholds
	localparam logic [4:0] QUAL_BITS_SHORT = 5'h0A;
	localparam logic [4:0] QUAL_BITS_LONG = 5'h18;
	localparam logic [11:0] LOS_ZEROS_SHORT = 12'h0FF;
	localparam logic [11:0] LOS_ZEROS_LONG = 12'h800;
	localparam logic [1:0] FRAME_ERR_LIMIT = 2'h3;
	localparam logic [3:0] LOOP_LEN_LONG = 4'h8;

	// receiver run state
	typedef enum logic [1:0] {
		ST_CONFIG = 2'b00,
		ST_LOW_POWER = 2'b01,
		ST_RUN = 2'b10,
		ST_SOFT_RESET = 2'b11
	} rfcsm_state_e;
endpackage

// ### src/rfcsm_top.sv
// Notes on behaviour
// - eight ports each decode own register copy at base plus 200h per port
// - sa8 history holds odd frames 15..1 in bits 7..0
// - last-sa register shows latest sa4..sa8 in bits 4..0, upper zero
// - change on a masked sa position sets latched status seven bit 0
// - sa6 codeword bits 3:0 captured without submultiframe alignment
// - framer enable 0 holds framer in low power, 1 makes it active
// - after initialisation complete, framer enable decides whether operation starts
// - sync disable 1 stops receive synchroniser, 0 runs it
// - soft reset is level held receiver reset, keeps register contents
// - standard select picks t1 or e1 and the control register view
// - t1 sync qualify time selects 10 or 24 bits
// - zero suppression bit 6 enables b8zs in t1, hdb3 in e1
// - t1 frame format 0 is esf, 1 is d4
// - t1 auto resync on oof or los when 0, oof only when 1
// - t1 sync criteria: d4 cross couple, esf crc-6 verify when set
// - t1 japanese crc selects the jt-g704 crc-6 variant
// - resync bit rising edge starts resync; sync enable 1 blocks auto resync
// - e1 signalling mode 0 is cas, 1 is ccs
// - e1 g802 option forces channel block high at ts26 bit 1
// - e1 crc-4 enable; resync after three fas or fas/nfas-bit2 errors
// - t1 up and down code lengths decode to 1..7 bits, 111 long code
// - e1 los after 255 zeros, or 2048 with alternate criterion
`timescale 1ns/1ps

module rfcsm_port
	import rfcsm_pkg::*;
(
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic wr_i,
	input wire logic [8:0] off_i,
	input wire logic [7:0] wdata_i,
	output logic [7:0] rdata_o,
	output logic hit_o,
	input wire logic sa_stb_i,
	input wire logic [3:0] sa_frame_i,
	input wire logic [4:0] sa_bits_i,
	input wire logic line_stb_i,
	input wire logic line_one_i,
	input wire logic oof_i,
	input wire logic word_chk_i,
	input wire logic word_fas_i,
	input wire logic word_err_i,
	input wire logic chblk_i,
	input wire logic ts26_b1_i,
	output logic run_o,
	output logic low_power_o,
	output logic e1_mode_o,
	output logic sync_run_o,
	output logic resync_o,
	output logic los_o,
	output logic zero_sup_o,
	output logic d4_mode_o,
	output logic [4:0] qual_bits_o,
	output logic cross_couple_o,
	output logic crc_check_o,
	output logic jap_crc_o,
	output logic ccs_mode_o,
	output logic [3:0] up_len_o,
	output logic [3:0] down_len_o,
	output logic chblk_o
);
	typedef struct packed {
		logic [7:0] master_mode;
		logic [7:0] control_one;
		logic [7:0] control_two;
		logic [7:0] sa_mon_mask;
		logic [7:0] sa8_hist;
		logic [4:0] sa_last;
		logic [3:0] sa6_shift;
		logic [3:0] sa6_code;
		logic [1:0] sa6_phase;
		logic sa_changed;
		logic resync_prev;
		logic [11:0] zero_count;
		logic [1:0] err_count;
		rfcsm_state_e state;
		logic run;
		logic low_power;
		logic e1_mode;
		logic sync_run;
		logic resync;
		logic los;
		logic zero_sup;
		logic d4_mode;
		logic [4:0] qual_bits;
		logic cross_couple;
		logic crc_check;
		logic jap_crc;
		logic ccs_mode;
		logic [3:0] up_len;
		logic [3:0] down_len;
		logic chblk;
	} rfcsm_port_s;

	rfcsm_port_s st_reg;
	rfcsm_port_s st_next;

	// register read view; the shared offsets follow the current standard
	always_comb
	begin
		rdata_o = RESET_BYTE;
		hit_o = 1'b1;
		unique case (off_i)
			OFF_SA8_HIST: rdata_o = st_reg.sa8_hist;
			OFF_SA_LAST: rdata_o = {3'h0, st_reg.sa_last};
			OFF_SA6_CODE: rdata_o = {4'h0, st_reg.sa6_code};
			OFF_MASTER_MODE: rdata_o = st_reg.master_mode;
			OFF_CONTROL_ONE: rdata_o = st_reg.control_one &
				(st_reg.master_mode[MM_STD_SEL] ? MASK_C1_E1 : MASK_C1_T1);
			OFF_CONTROL_TWO: rdata_o = st_reg.control_two &
				(st_reg.master_mode[MM_STD_SEL] ? MASK_C2_E1 : MASK_C2_T1);
			OFF_SA_MON_MASK: rdata_o = st_reg.sa_mon_mask;
			OFF_LATCHED_SEVEN: rdata_o = {7'h00, st_reg.sa_changed};
			default: hit_o = 1'b0;
		endcase
	end

	// whole port behaviour in one pass
	always_comb
	begin
		logic e1;
		logic running;
		logic soft_rst;
		logic sa_event;
		logic [4:0] sa_diff;
		logic resync_edge;
		logic auto_req;
		logic los_now;
		logic [11:0] los_limit;
		logic [7:0] c1;
		logic [7:0] c2;
		e1 = 1'b0;
		running = 1'b0;
		soft_rst = 1'b0;
		sa_event = 1'b0;
		sa_diff = 5'h00;
		resync_edge = 1'b0;
		auto_req = 1'b0;
		los_now = 1'b0;
		los_limit = LOS_ZEROS_SHORT;
		c1 = 8'h00;
		c2 = 8'h00;
		st_next = st_reg;

		// software writes; reserved bits are masked off before storing
		if (wr_i)
		begin
			unique case (off_i)
				OFF_MASTER_MODE: st_next.master_mode = wdata_i & MASK_MASTER_MODE;
				OFF_CONTROL_ONE: st_next.control_one = wdata_i &
					(st_reg.master_mode[MM_STD_SEL] ? MASK_C1_E1 : MASK_C1_T1);
				OFF_CONTROL_TWO: st_next.control_two = wdata_i &
					(st_reg.master_mode[MM_STD_SEL] ? MASK_C2_E1 : MASK_C2_T1);
				OFF_SA_MON_MASK: st_next.sa_mon_mask = wdata_i & MASK_SA_MON;
				OFF_LATCHED_SEVEN:
				begin
					if (wdata_i[0])
					begin
						st_next.sa_changed = 1'b0;
					end
				end
				default:
				begin
				end
			endcase
		end

		e1 = st_reg.master_mode[MM_STD_SEL];
		c1 = st_reg.control_one;
		c2 = st_reg.control_two;
		soft_rst = st_reg.master_mode[MM_SOFT_RST];

		// run state: soft reset dominates, then init done, then framer enable
		if (soft_rst)
		begin
			st_next.state = ST_SOFT_RESET;
		end
		else if (!st_reg.master_mode[MM_INIT_DONE])
		begin
			st_next.state = ST_CONFIG;
		end
		else if (st_reg.master_mode[MM_FRAMER_EN])
		begin
			st_next.state = ST_RUN;
		end
		else
		begin
			st_next.state = ST_LOW_POWER;
		end
		running = (st_reg.state == ST_RUN);

		// sa monitoring lives in e1 only; only the sa8 history is limited to odd frames
		sa_event = running && e1 && sa_stb_i;
		sa_diff = (sa_bits_i ^ st_reg.sa_last) & st_reg.sa_mon_mask[4:0];
		if (sa_event)
		begin
			st_next.sa_last = sa_bits_i;
			if (sa_frame_i[0])
			begin
				st_next.sa8_hist[sa_frame_i[3:1]] = sa_bits_i[0];
			end
			// no submultiframe alignment, so any rotation of the code appears
			st_next.sa6_shift = {st_reg.sa6_shift[2:0], sa_bits_i[2]};
			st_next.sa6_phase = st_reg.sa6_phase + 2'h1;
			if (st_reg.sa6_phase == 2'h3)
			begin
				st_next.sa6_code = {st_reg.sa6_shift[2:0], sa_bits_i[2]};
			end
			if (sa_diff != 5'h00)
			begin
				st_next.sa_changed = 1'b1;
			end
		end

		// zero run counter feeding loss of signal
		los_limit = (e1 && c2[C2_LOS_ALT]) ? LOS_ZEROS_LONG : LOS_ZEROS_SHORT;
		if (running && line_stb_i)
		begin
			if (line_one_i)
			begin
				st_next.zero_count = 12'h000;
			end
			else if (st_reg.zero_count < los_limit)
			begin
				st_next.zero_count = st_reg.zero_count + 12'h001;
			end
		end
		los_now = running && (st_reg.zero_count >= los_limit);

		// e1 consecutive framing word errors
		if (running && e1 && word_chk_i && (word_fas_i || c1[C1_RESYNC_CRIT]))
		begin
			if (!word_err_i)
			begin
				st_next.err_count = 2'h0;
			end
			else if (st_reg.err_count != FRAME_ERR_LIMIT)
			begin
				st_next.err_count = st_reg.err_count + 2'h1;
			end
		end

		// manual resync needs a fresh rising edge every time
		st_next.resync_prev = c1[C1_RESYNC];
		resync_edge = c1[C1_RESYNC] && !st_reg.resync_prev;
		if (e1)
		begin
			auto_req = (st_reg.err_count == FRAME_ERR_LIMIT);
		end
		else
		begin
			auto_req = oof_i || (los_now && !c1[C1_AUTO_CRIT]);
		end
		auto_req = auto_req && !c1[C1_AUTO_DIS];
		st_next.resync = running && !st_reg.master_mode[MM_SYNC_DIS] &&
			(resync_edge || auto_req);
		if (st_next.resync)
		begin
			st_next.err_count = 2'h0;
		end

		// soft reset clears receiver state, never the registers
		if (soft_rst)
		begin
			st_next.zero_count = 12'h000;
			st_next.err_count = 2'h0;
			st_next.sa6_phase = 2'h0;
			st_next.resync = 1'b0;
		end

		// decoded configuration seen by the framer datapath
		st_next.run = running;
		st_next.low_power = !running;
		st_next.e1_mode = e1;
		st_next.sync_run = running && !st_reg.master_mode[MM_SYNC_DIS];
		st_next.los = los_now;
		st_next.zero_sup = c1[C1_ZERO_SUP];
		st_next.d4_mode = !e1 && c1[C1_FRAME_FMT];
		st_next.qual_bits = c1[C1_SYNC_QUAL] ? QUAL_BITS_LONG : QUAL_BITS_SHORT;
		st_next.cross_couple = !e1 && c1[C1_FRAME_FMT] && c1[C1_SYNC_CRIT];
		st_next.crc_check = e1 ? c1[C1_CRC_EN] :
			(!c1[C1_FRAME_FMT] && c1[C1_SYNC_CRIT]);
		st_next.jap_crc = !e1 && c1[C1_JAP_CRC];
		st_next.ccs_mode = e1 && c1[C1_SIG_MODE];
		st_next.up_len = (c2[5:3] == 3'h7) ? LOOP_LEN_LONG :
			{1'b0, c2[5:3]} + 4'h1;
		st_next.down_len = (c2[2:0] == 3'h7) ? LOOP_LEN_LONG :
			{1'b0, c2[2:0]} + 4'h1;
		if (e1)
		begin
			st_next.up_len = 4'h0;
			st_next.down_len = 4'h0;
		end
		st_next.chblk = chblk_i || (e1 && c1[C1_G802] && ts26_b1_i);
	end

	// single state register; reset brings every field to zero
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			st_reg <= '0;
		end
		else
		begin
			st_reg <= st_next;
		end
	end

	assign run_o = st_reg.run;
	assign low_power_o = st_reg.low_power;
	assign e1_mode_o = st_reg.e1_mode;
	assign sync_run_o = st_reg.sync_run;
	assign resync_o = st_reg.resync;
	assign los_o = st_reg.los;
	assign zero_sup_o = st_reg.zero_sup;
	assign d4_mode_o = st_reg.d4_mode;
	assign qual_bits_o = st_reg.qual_bits;
	assign cross_couple_o = st_reg.cross_couple;
	assign crc_check_o = st_reg.crc_check;
	assign jap_crc_o = st_reg.jap_crc;
	assign ccs_mode_o = st_reg.ccs_mode;
	assign up_len_o = st_reg.up_len;
	assign down_len_o = st_reg.down_len;
	assign chblk_o = st_reg.chblk;
endmodule

module rfcsm_top
	import rfcsm_pkg::*;
(
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [15:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	input wire logic [7:0] sa_stb_i,
	input wire logic [7:0][3:0] sa_frame_i,
	input wire logic [7:0][4:0] sa_bits_i,
	input wire logic [7:0] line_stb_i,
	input wire logic [7:0] line_one_i,
	input wire logic [7:0] oof_i,
	input wire logic [7:0] word_chk_i,
	input wire logic [7:0] word_fas_i,
	input wire logic [7:0] word_err_i,
	input wire logic [7:0] chblk_i,
	input wire logic [7:0] ts26_b1_i,
	output logic [7:0] run_o,
	output logic [7:0] low_power_o,
	output logic [7:0] e1_mode_o,
	output logic [7:0] sync_run_o,
	output logic [7:0] resync_o,
	output logic [7:0] los_o,
	output logic [7:0] zero_sup_o,
	output logic [7:0] d4_mode_o,
	output logic [7:0][4:0] qual_bits_o,
	output logic [7:0] cross_couple_o,
	output logic [7:0] crc_check_o,
	output logic [7:0] jap_crc_o,
	output logic [7:0] ccs_mode_o,
	output logic [7:0][3:0] up_len_o,
	output logic [7:0][3:0] down_len_o,
	output logic [7:0] chblk_o
);
	typedef struct packed {
		logic ack;
		logic [31:0] dat;
	} rfcsm_bus_s;

	rfcsm_bus_s bus_reg;
	rfcsm_bus_s bus_next;
	logic [7:0][7:0] port_rdata;
	logic [7:0] port_hit;
	logic [7:0] port_wr;
	logic [11:0] word_idx;
	logic [2:0] port_sel;
	logic take;

	// word index = byte address / 4; upper index bits pick the port
	assign word_idx = wb_adr_i[13:2];
	assign port_sel = word_idx[11:9];
	assign take = wb_cyc_i && wb_stb_i && !bus_reg.ack;

	// write strobes fire at the ack edge, so a write lands only when the master completes it
	always_comb
	begin
		port_wr = 8'h00;
		if (wb_cyc_i && wb_stb_i && bus_reg.ack && wb_we_i && wb_sel_i[0] &&
			(wb_adr_i[15:14] == 2'h0))
		begin
			port_wr[port_sel] = 1'b1;
		end
	end

	// one-wait-state slave; unmapped reads return zero, writes vanish
	always_comb
	begin
		bus_next = bus_reg;
		bus_next.ack = take;
		if (take)
		begin
			bus_next.dat = 32'h0000_0000;
			if (!wb_we_i && (wb_adr_i[15:14] == 2'h0) && port_hit[port_sel])
			begin
				bus_next.dat = {24'h00_0000, port_rdata[port_sel]};
			end
		end
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			bus_reg <= '0;
		end
		else
		begin
			bus_reg <= bus_next;
		end
	end

	assign wb_ack_o = bus_reg.ack;
	assign wb_dat_o = bus_reg.dat;

	// one register copy per line port
	for (genvar p = 0; p < PORT_COUNT; p++)
	begin : g_port
		rfcsm_port u_port (
			.clk_i(clk_i),
			.rst_i(rst_i),
			.wr_i(port_wr[p]),
			.off_i(word_idx[8:0]),
			.wdata_i(wb_dat_i[7:0]),
			.rdata_o(port_rdata[p]),
			.hit_o(port_hit[p]),
			.sa_stb_i(sa_stb_i[p]),
			.sa_frame_i(sa_frame_i[p]),
			.sa_bits_i(sa_bits_i[p]),
			.line_stb_i(line_stb_i[p]),
			.line_one_i(line_one_i[p]),
			.oof_i(oof_i[p]),
			.word_chk_i(word_chk_i[p]),
			.word_fas_i(word_fas_i[p]),
			.word_err_i(word_err_i[p]),
			.chblk_i(chblk_i[p]),
			.ts26_b1_i(ts26_b1_i[p]),
			.run_o(run_o[p]),
			.low_power_o(low_power_o[p]),
			.e1_mode_o(e1_mode_o[p]),
			.sync_run_o(sync_run_o[p]),
			.resync_o(resync_o[p]),
			.los_o(los_o[p]),
			.zero_sup_o(zero_sup_o[p]),
			.d4_mode_o(d4_mode_o[p]),
			.qual_bits_o(qual_bits_o[p]),
			.cross_couple_o(cross_couple_o[p]),
			.crc_check_o(crc_check_o[p]),
			.jap_crc_o(jap_crc_o[p]),
			.ccs_mode_o(ccs_mode_o[p]),
			.up_len_o(up_len_o[p]),
			.down_len_o(down_len_o[p]),
			.chblk_o(chblk_o[p])
		);
	end
endmodule

// ### test/rfcsm_host.sv
`timescale 1ns/1ps
// host processor side of the register port, classic single cycles
module rfcsm_host (
	input wire logic clk_i,
	output logic cyc_o,
	output logic stb_o,
	output logic we_o,
	output logic [15:0] adr_o,
	output logic [3:0] sel_o,
	output logic [31:0] dat_o,
	input wire logic ack_i,
	input wire logic [31:0] dat_i
);
	// idle bus at time zero
	initial
	begin
		cyc_o = 1'b0;
		stb_o = 1'b0;
		we_o = 1'b0;
		adr_o = 16'h0000;
		sel_o = 4'h0;
		dat_o = 32'h00000000;
	end

	// request held until ack is sampled; released data inverts so stale values never match
	task automatic xfer(input logic w, input logic [15:0] a, input logic [7:0] d,
		output logic [7:0] rd, output logic ok);
		ok = 1'b0;
		@(posedge clk_i);
		cyc_o <= 1'b1;
		stb_o <= 1'b1;
		we_o <= w;
		adr_o <= a;
		sel_o <= 4'h1;
		dat_o <= {24'h000000, d};
		for (int n = 0; n < 16 && !ok; n++)
		begin
			@(posedge clk_i);
			ok = ack_i;
		end
		rd = dat_i[7:0];
		cyc_o <= 1'b0;
		stb_o <= 1'b0;
		dat_o <= ~dat_o;
	endtask
endmodule

// ### test/rfcsm_sva.sv
`timescale 1ns/1ps
// watches the register port and the decodes of the top
module rfcsm_sva (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic [31:0] wb_dat_o,
	input wire logic wb_ack_o,
	input wire logic [7:0] chblk_i,
	input wire logic [7:0] run_o,
	input wire logic [7:0] low_power_o,
	input wire logic [7:0] e1_mode_o,
	input wire logic [7:0] sync_run_o,
	input wire logic [7:0] d4_mode_o,
	input wire logic [7:0][3:0] up_len_o,
	input wire logic [7:0] chblk_o
);
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (rst_i);

	// answer one cycle after a taken request, and for one cycle only
	a_ack_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
		else $error("request not answered");
	a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack too long");
	a_upper_zero: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h000000)
		else $error("upper lanes not zero");
	// decode relations; low power is the exact complement of run once out of reset
	a_low_power: assert property (!$past(rst_i) |-> low_power_o == ~run_o)
		else $error("running port in low power");
	a_sync_run: assert property ((sync_run_o & ~run_o) == 8'h00)
		else $error("sync runs while stopped");
	a_e1_lengths: assert property (e1_mode_o[0] |-> up_len_o[0] == 4'h0)
		else $error("loop length in e1");
	a_d4_only_t1: assert property (d4_mode_o[0] |-> !e1_mode_o[0])
		else $error("d4 framing in e1");
	// channel block passes through after one cycle
	a_chblk_pass: assert property (chblk_i[0] |=> chblk_o[0])
		else $error("channel block lost");
endmodule

bind rfcsm_top rfcsm_sva u_sva (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_dat_o, .wb_ack_o,
	.chblk_i, .run_o, .low_power_o, .e1_mode_o, .sync_run_o, .d4_mode_o, .up_len_o, .chblk_o);

// ### test/rfcsm_top_test.sv
`timescale 1ns/1ps
module rfcsm_top_test
	import rfcsm_pkg::*;
;
	localparam logic [7:0] T1V [3] = '{8'hEC, 8'h08, 8'h00};
	logic clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
	logic [15:0] wb_adr_i;
	logic [3:0] wb_sel_i;
	logic [31:0] wb_dat_i, wb_dat_o;
	logic [7:0] sa_stb_i, line_stb_i, line_one_i, oof_i, word_chk_i, word_fas_i, word_err_i;
	logic [7:0] chblk_i, ts26_b1_i, run_o, low_power_o, e1_mode_o, sync_run_o, resync_o, los_o;
	logic [7:0] zero_sup_o, d4_mode_o, cross_couple_o, crc_check_o, jap_crc_o, ccs_mode_o, chblk_o;
	logic [7:0][3:0] sa_frame_i, up_len_o, down_len_o;
	logic [7:0][4:0] sa_bits_i, qual_bits_o;
	logic [7:0] r;
	int n_mismatch, n_compared, n_rs;

	rfcsm_top uut (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
		.wb_dat_i, .wb_dat_o, .wb_ack_o, .sa_stb_i, .sa_frame_i, .sa_bits_i, .line_stb_i,
		.line_one_i, .oof_i, .word_chk_i, .word_fas_i, .word_err_i, .chblk_i, .ts26_b1_i,
		.run_o, .low_power_o, .e1_mode_o, .sync_run_o, .resync_o, .los_o, .zero_sup_o,
		.d4_mode_o, .qual_bits_o, .cross_couple_o, .crc_check_o, .jap_crc_o, .ccs_mode_o,
		.up_len_o, .down_len_o, .chblk_o);
	rfcsm_host host (.clk_i, .cyc_o(wb_cyc_i), .stb_o(wb_stb_i), .we_o(wb_we_i),
		.adr_o(wb_adr_i), .sel_o(wb_sel_i), .dat_o(wb_dat_i), .ack_i(wb_ack_o), .dat_i(wb_dat_o));

	// clock
	initial
	begin
		clk_i = 1'b0;
		forever #50 clk_i = ~clk_i;
	end

	// resync pulses of port 0, sampled at each edge so none is missed
	always @(posedge clk_i)
	begin
		if (resync_o[0] === 1'b1)
			n_rs <= n_rs + 1;
	end

	task automatic final_report();
		$display("compared %0d mismatched %0d", n_compared, n_mismatch);
		if (n_mismatch == 0 && n_compared > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp)
		begin
			n_mismatch++;
			$display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	// a missing ack is a mismatch and ends the run
	task automatic bus(input logic w, input logic [15:0] a, input logic [7:0] d);
		logic ok;
		host.xfer(w, a, d, r, ok);
		if (ok !== 1'b1)
		begin
			n_mismatch++;
			final_report();
		end
	endtask

	// port index 0..7 and word offset to byte address
	task automatic wr(input int p, input logic [8:0] o, input logic [7:0] d);
		bus(1'b1, {2'b00, p[2:0], o, 2'b00}, d);
	endtask

	task automatic rc(input int p, input logic [8:0] o, input logic [7:0] e);
		bus(1'b0, {2'b00, p[2:0], o, 2'b00}, 8'h00);
		chk(r, e);
	endtask

	// let registered decodes land
	task automatic settle();
		repeat (2) @(posedge clk_i);
		#1;
	endtask

	// line bits, framing words and sa strobes, all on port 0
	task automatic feed(input logic one, input int n);
		@(posedge clk_i);
		line_stb_i <= 8'h01;
		line_one_i <= {7'h00, one};
		repeat (n) @(posedge clk_i);
		line_stb_i <= 8'h00;
	endtask

	task automatic word(input logic fas, input logic err);
		@(posedge clk_i);
		word_chk_i <= 8'h01;
		word_fas_i <= {7'h00, fas};
		word_err_i <= {7'h00, err};
		@(posedge clk_i);
		word_chk_i <= 8'h00;
	endtask

	task automatic sa(input int f, input logic [4:0] b);
		@(posedge clk_i);
		sa_stb_i <= 8'h01;
		sa_frame_i[0] <= 4'(f);
		sa_bits_i[0] <= b;
		@(posedge clk_i);
		sa_stb_i <= 8'h00;
	endtask

	// reset values, masks, soft reset, start-up order, port separation
	task automatic t_regs();
		rc(0, OFF_MASTER_MODE, RESET_BYTE);
		rc(7, OFF_CONTROL_TWO, RESET_BYTE);
		chk(low_power_o, 8'hFF);
		wr(0, OFF_MASTER_MODE, 8'hFF);
		rc(0, OFF_MASTER_MODE, MASK_MASTER_MODE);
		settle();
		chk(run_o, 8'h00);
		wr(0, OFF_MASTER_MODE, 8'hE1);
		wr(2, OFF_MASTER_MODE, 8'h81);
		settle();
		chk(run_o, 8'h01);
		chk(sync_run_o, 8'h00);
		rc(0, OFF_MASTER_MODE, 8'hE1);
		rc(1, OFF_MASTER_MODE, RESET_BYTE);
		wr(0, OFF_MASTER_MODE, 8'hC1);
		wr(2, OFF_MASTER_MODE, 8'hC1);
		settle();
		chk(sync_run_o, 8'h05);
		wr(2, OFF_MASTER_MODE, 8'h41);
		settle();
		chk(low_power_o, 8'hFE);
		wr(0, OFF_SA_LAST, 8'hFF);
		rc(0, OFF_SA_LAST, RESET_BYTE);
		bus(1'b1, 16'hC000, 8'hFF);
		bus(1'b0, 16'hC000, 8'hFF);
		chk(r, 8'h00);
	endtask

	// t1 decodes, loop code lengths, manual resync edges
	task automatic t_t1();
		logic [7:0] v;
		int c;
		wr(0, OFF_MASTER_MODE, 8'hC0);
		foreach (T1V[i])
		begin
			v = T1V[i];
			wr(0, OFF_CONTROL_ONE, v);
			settle();
			chk(e1_mode_o[0], 1'b0);
			chk(qual_bits_o[0], v[7] ? QUAL_BITS_LONG : QUAL_BITS_SHORT);
			chk(zero_sup_o[0], v[6]);
			chk(d4_mode_o[0], v[5]);
			chk(cross_couple_o[0], v[5] & v[3]);
			chk(crc_check_o[0], !v[5] & v[3]);
			chk(jap_crc_o[0], v[2]);
		end
		for (int i = 0; i < 8; i++)
		begin
			wr(0, OFF_CONTROL_TWO, {2'b00, 3'(i), 3'(7 - i)});
			settle();
			chk(up_len_o[0], i == 7 ? LOOP_LEN_LONG : 4'(i + 1));
			chk(down_len_o[0], i == 0 ? LOOP_LEN_LONG : 4'(8 - i));
		end
		c = n_rs;
		wr(0, OFF_CONTROL_ONE, 8'h01);
		wr(0, OFF_CONTROL_ONE, 8'h01);
		settle();
		chk(n_rs - c, 1);
		wr(0, OFF_CONTROL_ONE, 8'h00);
		wr(0, OFF_CONTROL_ONE, 8'h01);
		settle();
		chk(n_rs - c, 2);
		// t1 auto resync: out of frame always, loss of signal only with the criterion bit clear
		@(posedge clk_i);
		oof_i <= 8'h01;
		@(posedge clk_i);
		oof_i <= 8'h00;
		settle();
		chk(n_rs - c, 3);
		wr(0, OFF_CONTROL_ONE, 8'h10);
		feed(1'b0, 255);
		settle();
		chk(los_o[0], 1'b1);
		chk(n_rs - c, 3);
		wr(0, OFF_CONTROL_ONE, 8'h00);
		feed(1'b1, 1);
		settle();
		chk(n_rs - c > 3, 1'b1);
	endtask

	// e1 view of the shared registers and channel block forcing
	task automatic t_e1();
		wr(0, OFF_MASTER_MODE, 8'hC1);
		wr(0, OFF_CONTROL_ONE, 8'hB8);
		rc(0, OFF_CONTROL_ONE, 8'h38);
		chk(ccs_mode_o[0], 1'b1);
		chk(crc_check_o[0], 1'b1);
		@(posedge clk_i);
		ts26_b1_i <= 8'h01;
		settle();
		chk(chblk_o[0], 1'b1);
		wr(0, OFF_CONTROL_ONE, 8'h48);
		settle();
		chk(chblk_o[0], 1'b0);
		chk(ccs_mode_o[0], 1'b0);
		chk(zero_sup_o[0], 1'b1);
		@(posedge clk_i);
		chblk_i <= 8'h01;
		settle();
		chk(chblk_o[0], 1'b1);
		@(posedge clk_i);
		chblk_i <= 8'h00;
		ts26_b1_i <= 8'h00;
		wr(0, OFF_CONTROL_TWO, 8'hFF);
		rc(0, OFF_CONTROL_TWO, MASK_C2_E1);
	endtask

	// loss of signal at both zero-run thresholds, right at the boundary
	task automatic t_los();
		feed(1'b1, 1);
		feed(1'b0, 2047);
		settle();
		chk(los_o[0], 1'b0);
		feed(1'b0, 1);
		settle();
		chk(los_o[0], 1'b1);
		wr(0, OFF_CONTROL_TWO, 8'h00);
		feed(1'b1, 1);
		feed(1'b0, 254);
		settle();
		chk(los_o[0], 1'b0);
		feed(1'b0, 1);
		settle();
		chk(los_o[0], 1'b1);
	endtask

	// framing word errors; a good word breaks the run
	task automatic t_fas();
		int c;
		c = n_rs;
		word(1'b1, 1'b1);
		word(1'b1, 1'b1);
		word(1'b1, 1'b0);
		word(1'b1, 1'b1);
		word(1'b1, 1'b1);
		settle();
		chk(n_rs - c, 0);
		word(1'b1, 1'b1);
		settle();
		chk(n_rs - c, 1);
		wr(0, OFF_CONTROL_ONE, 8'h04);
		repeat (3) word(1'b0, 1'b1);
		settle();
		chk(n_rs - c, 2);
		wr(0, OFF_CONTROL_ONE, 8'h06);
		repeat (3) word(1'b1, 1'b1);
		settle();
		chk(n_rs - c, 2);
	endtask

	// sa history, last bits, masked change latch, sa6 codeword
	task automatic t_sa();
		logic [7:0] p;
		p = 8'hA5;
		wr(0, OFF_SA_MON_MASK, 8'h02);
		for (int i = 0; i < 8; i++)
		begin
			sa(2 * i, {4'h0, !p[i]});
			sa(2 * i + 1, {4'h0, p[i]});
		end
		rc(0, OFF_SA8_HIST, p);
		rc(0, OFF_SA_LAST, 8'h01);
		rc(0, OFF_LATCHED_SEVEN, 8'h00);
		sa(3, 5'h03);
		rc(0, OFF_LATCHED_SEVEN, 8'h01);
		rc(0, OFF_SA_LAST, 8'h03);
		rc(0, OFF_SA8_HIST, 8'hA7);
		wr(0, OFF_LATCHED_SEVEN, 8'h01);
		rc(0, OFF_LATCHED_SEVEN, 8'h00);
		for (int i = 0; i < 8; i++)
			sa(1, {2'b00, i[0], 2'b00});
		bus(1'b0, {5'h00, OFF_SA6_CODE, 2'b00}, 8'h00);
		chk((r === 8'h0A) || (r === 8'h05), 1'b1);
		repeat (8) sa(1, 5'h04);
		rc(0, OFF_SA6_CODE, 8'h0F);
	endtask

	// main sequence
	initial
	begin
		rst_i = 1'b1;
		{sa_stb_i, line_stb_i, line_one_i, oof_i, word_chk_i, word_fas_i, word_err_i} = '0;
		{chblk_i, ts26_b1_i, sa_frame_i, sa_bits_i} = '0;
		repeat (5) @(posedge clk_i);
		rst_i <= 1'b0;
		t_regs();
		t_t1();
		t_e1();
		t_los();
		t_fas();
		t_sa();
		final_report();
	end
endmodule
